//--- rtl/cec_map.svh
// Register offsets and field positions for the error counter pair.
// Assumes an APB slave with 32-bit data; offsets are byte addresses.
`ifndef CEC_MAP_SVH
`define CEC_MAP_SVH
`define CEC_STATUS_OFF     12'h000
`define CEC_ADDR_OFF       12'h004
`define CEC_MISC0_OFF      12'h008
`define CEC_CTRL_OFF       12'h00c
`define CEC_IRQ_STAT_OFF   12'h010
`define CEC_IRQ_MASK_OFF   12'h014
`define CEC_ST_V_BIT       31
`define CEC_ST_ADDR_VALID_BIT   30
`define CEC_ST_MISC_VALID_BIT   29
`define CEC_ST_ARCH_CODE_LSB    0
`define CEC_ST_IMPL_CODE_LSB    8
`define CEC_M0_REP_LSB     32
`define CEC_M0_OTH_LSB     40
`define CEC_M0_OFR_BIT     63
`define CEC_M0_OFO_BIT     62
`define CEC_CTRL_IGN_ADDR_VALID 0
`define CEC_CTRL_IGN_MISC_VALID 1
`define CEC_CTRL_USE_MISC  2
`define CEC_IRQ_OVF_REP    0
`define CEC_IRQ_OVF_OTH    1
`define CEC_IRQ_CE_EVT     2
`define CEC_IRQ_W          3
`endif

//--- rtl/cec_pkg.sv
// Types shared by the counter pair block.
// Assumes nothing beyond the map header.
package cec_pkg;
    typedef enum logic [1:0] {
        CNT_IDLE = 2'b01,
        CNT_BUMP = 2'b10
    } cnt_state_t;
endpackage

//--- rtl/cec_counter.sv
// One wrapping corrected error counter with a sticky overflow flag.
// Assumes the parent gives a single-cycle bump and a one-cycle clear.
`timescale 1ns/100ps
`default_nettype none
module cec_counter #(
    parameter int W = 8
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         bump,
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    input  wire logic         clr_ovf,
    output logic      [W-1:0] count,
    output logic              ovf,
    output logic              wrap
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic         ovf;
        logic         wrap;
    } ctr_t;
    ctr_t st_q;   // Registered state
    ctr_t st_d;   // Next state

    // Counting, wrapping and overflow flag
    always_comb begin
        st_d      = st_q;
        st_d.wrap = 1'b0;
        if (load) begin
            st_d.cnt = load_val;
        end else if (bump) begin
            st_d.cnt = st_q.cnt + 1'b1;
            if (&st_q.cnt) begin
                st_d.wrap = 1'b1;
            end
        end
        // Set beats the clear
        if (clr_ovf) begin
            st_d.ovf = 1'b0;
        end
        if (bump && !load && (&st_q.cnt)) begin
            st_d.ovf = 1'b1;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign count = st_q.cnt;
    assign ovf   = st_q.ovf;
    assign wrap  = st_q.wrap;

    property p_wrap_zero;
        @(posedge pclk) disable iff (!presetn)
        (bump && !load && (&st_q.cnt)) |=> (st_q.cnt == '0) && st_q.ovf && st_q.wrap;
    endproperty
    a_wrap_zero: assert property (p_wrap_zero) else $error("counter did not wrap");

    property p_ovf_sticky;
        @(posedge pclk) disable iff (!presetn)
        (st_q.ovf && !clr_ovf) |=> st_q.ovf;
    endproperty
    a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag lost");
endmodule
`default_nettype wire

//--- rtl/cec_node.sv
// Error record with a repeat/other corrected error counter pair and APB access.
// Assumes a recording source pulses err_valid with a location and codes.
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "cec_map.svh"
module cec_node
    import cec_pkg::*;
#(
    parameter int CW = 8,   // Counter width
    parameter int AW = 32   // Location address width
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        err_valid,
    input  wire logic [AW-1:0] err_addr,
    input  wire logic [7:0]  err_impl_code,
    input  wire logic [7:0]  err_arch_code,
    input  wire logic [15:0] err_misc_loc,
    output logic             ce_event,
    output logic             irq
);
    typedef struct packed {
        cnt_state_t     state;
        logic           rec_v;
        logic           rec_addr_valid;
        logic           rec_misc_valid;
        logic [7:0]     impl_code;
        logic [7:0]     arch_code;
        logic [AW-1:0]  addr;
        logic [15:0]    mloc;
        logic           rep_sel;
        logic [2:0]     ctrl;
        logic [`CEC_IRQ_W-1:0] ist;
        logic [`CEC_IRQ_W-1:0] imsk;
        logic [31:0]    rdata;
        logic           ce_evt;
    } node_t;
    node_t st_q;   // Registered state
    node_t st_d;   // Next state

    logic          wr_en;     // APB write accepted
    logic          rd_en;     // APB read accepted
    logic          hit;       // Mapped address
    logic          loc_valid; // Counted-fault location valid
    logic          same_loc;  // New error matches stored location
    logic          bump_rep;  // Repeat counter bump
    logic          bump_oth;  // Other counter bump
    logic          ld_rep;    // Software loads repeat counter
    logic          ld_oth;    // Software loads other counter
    logic          clr_rep;   // Software clears repeat overflow
    logic          clr_oth;   // Software clears other overflow
    logic [CW-1:0] rep_cnt;   // Repeat count
    logic [CW-1:0] oth_cnt;   // Other count
    logic          rep_ovf;   // Repeat overflow flag
    logic          oth_ovf;   // Other overflow flag
    logic          rep_wrap;  // Repeat wrapped this cycle
    logic          oth_wrap;  // Other wrapped this cycle
    logic [63:0]   misc0;     // First misc syndrome register image

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    assign hit   = (paddr == `CEC_STATUS_OFF) || (paddr == `CEC_ADDR_OFF)
                || (paddr == `CEC_MISC0_OFF) || (paddr == `CEC_CTRL_OFF)
                || (paddr == `CEC_IRQ_STAT_OFF) || (paddr == `CEC_IRQ_MASK_OFF);

    // Location validity: record and address valid, plus misc valid when CEC_CTRL_USE_MISC is set; address and misc valid bits can be ignored
    always_comb begin
        loc_valid = st_q.rec_v;
        if (!st_q.rec_addr_valid && !st_q.ctrl[`CEC_CTRL_IGN_ADDR_VALID]) begin
            loc_valid = 1'b0;
        end
        if (st_q.ctrl[`CEC_CTRL_USE_MISC] && !st_q.rec_misc_valid
                && !st_q.ctrl[`CEC_CTRL_IGN_MISC_VALID]) begin
            loc_valid = 1'b0;
        end
    end

    // Same location compare over address and both codes, plus misc location when CEC_CTRL_USE_MISC is set
    always_comb begin
        same_loc = (err_addr == st_q.addr) && (err_impl_code == st_q.impl_code)
                && (err_arch_code == st_q.arch_code);
        if (st_q.ctrl[`CEC_CTRL_USE_MISC] && (err_misc_loc != st_q.mloc)) begin
            same_loc = 1'b0;
        end
    end

    // Counter choice on each recorded error
    assign bump_rep = err_valid && (!loc_valid || same_loc);
    assign bump_oth = err_valid && loc_valid && !same_loc;

    // Software access to the misc register
    assign ld_rep  = wr_en && (paddr == `CEC_MISC0_OFF) && pstrb[0];
    assign ld_oth  = wr_en && (paddr == `CEC_MISC0_OFF) && pstrb[1];
    assign clr_rep = wr_en && (paddr == `CEC_MISC0_OFF) && pstrb[3] && pwdata[31];
    assign clr_oth = wr_en && (paddr == `CEC_MISC0_OFF) && pstrb[3] && pwdata[30];

    // Repeat counter
    cec_counter #(.W(CW)) u_rep (
        .pclk     (pclk),
        .presetn  (presetn),
        .bump     (bump_rep),
        .load     (ld_rep),
        .load_val (pwdata[CW-1:0]),
        .clr_ovf  (clr_rep),
        .count    (rep_cnt),
        .ovf      (rep_ovf),
        .wrap     (rep_wrap)
    );

    // Other-location counter
    cec_counter #(.W(CW)) u_oth (
        .pclk     (pclk),
        .presetn  (presetn),
        .bump     (bump_oth),
        .load     (ld_oth),
        .load_val (pwdata[8+CW-1:8]),
        .clr_ovf  (clr_oth),
        .count    (oth_cnt),
        .ovf      (oth_ovf),
        .wrap     (oth_wrap)
    );

    // Counters held in the first misc syndrome register
    // Flags sit above both count fields so no count bit is hidden
    always_comb begin
        misc0 = '0;
        misc0[`CEC_M0_REP_LSB +: CW] = rep_cnt;
        misc0[`CEC_M0_OTH_LSB +: CW] = oth_cnt;
        misc0[`CEC_M0_OFR_BIT]       = rep_ovf;
        misc0[`CEC_M0_OFO_BIT]       = oth_ovf;
        misc0[15:0]                  = st_q.mloc;
    end

    // Recording, register writes, read data and interrupts
    always_comb begin
        st_d        = st_q;
        st_d.ce_evt = rep_wrap || oth_wrap;
        st_d.state  = err_valid ? CNT_BUMP : CNT_IDLE;
        // Status clear by write-one to valid
        if (wr_en && (paddr == `CEC_STATUS_OFF) && pstrb[3]) begin
            if (pwdata[`CEC_ST_V_BIT]) begin
                st_d.rec_v = 1'b0;
            end
            if (pwdata[`CEC_ST_ADDR_VALID_BIT]) begin
                st_d.rec_addr_valid = 1'b0;
            end
            if (pwdata[`CEC_ST_MISC_VALID_BIT]) begin
                st_d.rec_misc_valid = 1'b0;
            end
        end
        if (wr_en && (paddr == `CEC_CTRL_OFF) && pstrb[0]) begin
            st_d.ctrl = pwdata[2:0];
        end
        if (wr_en && (paddr == `CEC_IRQ_MASK_OFF) && pstrb[0]) begin
            st_d.imsk = pwdata[`CEC_IRQ_W-1:0];
        end
        if (wr_en && (paddr == `CEC_IRQ_STAT_OFF) && pstrb[0]) begin
            st_d.ist = st_q.ist & ~pwdata[`CEC_IRQ_W-1:0];
        end
        // Sticky events win over the clear
        st_d.ist[`CEC_IRQ_OVF_REP] = st_d.ist[`CEC_IRQ_OVF_REP] | rep_wrap;
        st_d.ist[`CEC_IRQ_OVF_OTH] = st_d.ist[`CEC_IRQ_OVF_OTH] | oth_wrap;
        st_d.ist[`CEC_IRQ_CE_EVT]  = st_d.ist[`CEC_IRQ_CE_EVT] | rep_wrap | oth_wrap;
        // Syndrome capture only when location was invalid
        if (err_valid && !loc_valid) begin
            st_d.rec_v   = 1'b1;
            st_d.rec_addr_valid = 1'b1;
            st_d.rec_misc_valid = 1'b1;
            st_d.addr      = err_addr;
            st_d.impl_code = err_impl_code;
            st_d.arch_code = err_arch_code;
            st_d.mloc    = err_misc_loc;
            st_d.rep_sel = 1'b1;
        end else if (err_valid) begin
            st_d.rec_v   = 1'b1;
            st_d.rep_sel = same_loc;
        end
        // Read data captured in setup phase
        st_d.rdata = 32'h0000_0000;
        if (rd_en) begin
            if (paddr == `CEC_STATUS_OFF) begin
                st_d.rdata = {st_q.rec_v, st_q.rec_addr_valid, st_q.rec_misc_valid,
                              13'h0000, st_q.impl_code, st_q.arch_code};
            end else if (paddr == `CEC_ADDR_OFF) begin
                st_d.rdata = 32'(st_q.addr);
            end else if (paddr == `CEC_MISC0_OFF) begin
                st_d.rdata = {misc0[`CEC_M0_OFR_BIT], misc0[`CEC_M0_OFO_BIT], 14'h0000,
                              misc0[`CEC_M0_OTH_LSB +: 8], misc0[`CEC_M0_REP_LSB +: 8]};
            end else if (paddr == `CEC_CTRL_OFF) begin
                st_d.rdata = {29'h0000_0000, st_q.ctrl};
            end else if (paddr == `CEC_IRQ_STAT_OFF) begin
                st_d.rdata = {29'h0000_0000, st_q.ist};
            end else if (paddr == `CEC_IRQ_MASK_OFF) begin
                st_d.rdata = {29'h0000_0000, st_q.imsk};
            end
        end else begin
            st_d.rdata = st_q.rdata;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q       <= '0;
            st_q.state <= CNT_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    assign prdata   = st_q.rdata;
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !hit;
    assign ce_event = st_q.ce_evt;
    assign irq      = |(st_q.ist & st_q.imsk);

    property p_rep_when_invalid;
        @(posedge pclk) disable iff (!presetn)
        (err_valid && !st_q.rec_v) |-> bump_rep && !bump_oth;
    endproperty
    a_rep_when_invalid: assert property (p_rep_when_invalid) else $error("repeat not chosen");

    property p_rep_same;
        @(posedge pclk) disable iff (!presetn)
        (err_valid && loc_valid && same_loc && !ld_rep)
        |=> (rep_cnt == $past(rep_cnt) + 1'b1);
    endproperty
    a_rep_same: assert property (p_rep_same) else $error("same location not repeat");

    property p_oth;
        @(posedge pclk) disable iff (!presetn)
        (err_valid && loc_valid && !same_loc && !ld_oth)
        |=> !st_q.rep_sel && (oth_cnt == $past(oth_cnt) + 1'b1);
    endproperty
    a_oth: assert property (p_oth) else $error("other counter not chosen");

    property p_invalid_v;
        @(posedge pclk) disable iff (!presetn)
        !st_q.rec_v |-> !loc_valid;
    endproperty
    a_invalid_v: assert property (p_invalid_v) else $error("location valid without record");

    property p_capture;
        @(posedge pclk) disable iff (!presetn)
        (err_valid && !loc_valid) |=> (st_q.addr == $past(err_addr)) && st_q.rec_v;
    endproperty
    a_capture: assert property (p_capture) else $error("syndrome not captured");

    property p_keep;
        @(posedge pclk) disable iff (!presetn)
        (err_valid && loc_valid) |=> $stable(st_q.addr) && $stable(st_q.impl_code);
    endproperty
    a_keep: assert property (p_keep) else $error("syndrome overwritten");

    property p_event;
        @(posedge pclk) disable iff (!presetn)
        (rep_wrap || oth_wrap) |=> ce_event ##1 (!ce_event || $past(rep_wrap || oth_wrap));
    endproperty
    a_event: assert property (p_event) else $error("no corrected event");

    property p_ovf_flag;
        @(posedge pclk) disable iff (!presetn)
        rep_wrap |-> rep_ovf && (rep_cnt == '0);
    endproperty
    a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag not set");

    // Each recorded error goes to exactly one counter
    property p_one_counter;
        @(posedge pclk) disable iff (!presetn)
        (st_q.state == CNT_BUMP) |-> ($past(bump_rep) != $past(bump_oth));
    endproperty
    a_one_counter: assert property (p_one_counter) else $error("counter choice not unique");

    // A wrap always leaves the event status bit set
    property p_irq_set;
        @(posedge pclk) disable iff (!presetn)
        (rep_wrap || oth_wrap) |=> st_q.ist[`CEC_IRQ_CE_EVT];
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("event status not set");
endmodule
`default_nettype wire

//--- verif/cec_node_tb_top.sv
// Self-checking bench for the corrected error counter pair node.
// Assumes the map header is on the include path and pready answers in time.
`timescale 1ns/100ps
`default_nettype none
`include "cec_map.svh"
module cec_node_tb_top;
    logic        pclk;        // Bus clock
    logic        presetn;     // Async reset, active low
    logic        psel;        // Bus select
    logic        penable;     // Access phase
    logic        pwrite;      // Direction
    logic [11:0] paddr;       // Byte address
    logic [31:0] pwdata;      // Write data
    logic [3:0]  pstrb;       // Byte strobes
    logic [31:0] prdata;      // Read data
    logic        pready;      // Transfer done
    logic        pslverr;     // Transfer error
    logic        err_valid;   // Error recorded pulse
    logic [31:0] err_addr;    // Error address
    logic [7:0]  err_impl_code; // Impl code
    logic [7:0]  err_arch_code; // Arch code
    logic [15:0] err_misc_loc;// Misc location
    logic        ce_event;    // Corrected event pulse
    logic        irq;         // Interrupt level
    int          failures;    // Mismatch count
    int          comparisons; // Compare count
    logic [31:0] rdat;        // Last read data
    logic        rerr;        // Last read error
    logic        ce;          // Sampled event

    cec_node #(.CW(8), .AW(32)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .err_valid(err_valid), .err_addr(err_addr), .err_impl_code(err_impl_code),
        .err_arch_code(err_arch_code), .err_misc_loc(err_misc_loc),
        .ce_event(ce_event), .irq(irq)
    );

    // Free-running 8 ns clock
    always #4 pclk = ~pclk;

    // Verdict and end of run
    task automatic stop_test();
        if (failures == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Compare seen against expected
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One bus transfer, held until pready at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask

    // Read and compare one register
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0000_0000, 4'h0);
        chk(nm, rdat, exp);
    endtask

    // One countable error; ce holds the event seen two edges on
    task automatic err(input logic [31:0] a, input logic [7:0] ie, input logic [7:0] se,
                       input logic [15:0] m);
        @(posedge pclk);
        err_valid    <= 1'b1;
        err_addr     <= a;
        err_impl_code <= ie;
        err_arch_code <= se;
        err_misc_loc <= m;
        @(posedge pclk);
        err_valid <= 1'b0;
        @(posedge pclk);
        #1;
        ce = ce_event;
    endtask

    // Empty record: repeat counter takes the error, syndrome captured
    task automatic t_capture();
        rd(`CEC_STATUS_OFF, 32'h0000_0000, "status at reset");
        rd(`CEC_MISC0_OFF, 32'h0000_0000, "misc0 at reset");
        err(32'h0000_1000, 8'h11, 8'h22, 16'h0033);
        rd(`CEC_MISC0_OFF, 32'h0000_0001, "misc0 first");
        rd(`CEC_STATUS_OFF, 32'he000_1122, "status captured");
        rd(`CEC_ADDR_OFF, 32'h0000_1000, "addr captured");
        chk("ce no wrap", {31'h0, ce}, 32'h0);
    endtask

    // Same location repeats; any differing part counts as other
    task automatic t_same_other();
        err(32'h0000_1000, 8'h11, 8'h22, 16'h0033);
        rd(`CEC_MISC0_OFF, 32'h0000_0002, "misc0 same");
        err(32'h0000_1004, 8'h11, 8'h22, 16'h0033);
        err(32'h0000_1000, 8'h12, 8'h22, 16'h0033);
        err(32'h0000_1000, 8'h11, 8'h23, 16'h0033);
        rd(`CEC_MISC0_OFF, 32'h0000_0302, "misc0 other");
        rd(`CEC_STATUS_OFF, 32'he000_1122, "status kept");
        rd(`CEC_ADDR_OFF, 32'h0000_1000, "addr kept");
        apb(1'b1, `CEC_CTRL_OFF, 32'h0000_0004, 4'hf);
        err(32'h0000_1000, 8'h11, 8'h22, 16'h0044);
        err(32'h0000_1000, 8'h11, 8'h22, 16'h0033);
        rd(`CEC_MISC0_OFF, 32'h0000_0403, "misc0 misc part");
    endtask

    // Address-valid clear makes the location invalid unless ignored
    task automatic t_valid_bits();
        apb(1'b1, `CEC_CTRL_OFF, 32'h0000_0000, 4'hf);
        apb(1'b1, `CEC_STATUS_OFF, 32'h4000_0000, 4'h8);
        err(32'h0000_2000, 8'h11, 8'h22, 16'h0033);
        rd(`CEC_MISC0_OFF, 32'h0000_0404, "misc0 av clear");
        rd(`CEC_ADDR_OFF, 32'h0000_2000, "addr recaptured");
        apb(1'b1, `CEC_STATUS_OFF, 32'h4000_0000, 4'h8);
        apb(1'b1, `CEC_CTRL_OFF, 32'h0000_0001, 4'hf);
        err(32'h0000_2000, 8'h11, 8'h22, 16'h0033);
        err(32'h0000_3000, 8'h11, 8'h22, 16'h0033);
        rd(`CEC_MISC0_OFF, 32'h0000_0505, "misc0 av ignored");
        rd(`CEC_STATUS_OFF, 32'ha000_1122, "status av ignored");
        apb(1'b1, `CEC_CTRL_OFF, 32'h0000_0000, 4'hf);
        apb(1'b1, `CEC_STATUS_OFF, 32'he000_0000, 4'h8);
        err(32'h0000_4000, 8'h11, 8'h22, 16'h0033);
        rd(`CEC_MISC0_OFF, 32'h0000_0506, "misc0 v clear");
        rd(`CEC_ADDR_OFF, 32'h0000_4000, "addr after v clear");
    endtask

    // Wrap of both counters, sticky flags, event, interrupt
    task automatic t_overflow();
        apb(1'b1, `CEC_MISC0_OFF, 32'h0000_ffff, 4'h3);
        err(32'h0000_4000, 8'h11, 8'h22, 16'h0033);
        chk("ce repeat wrap", {31'h0, ce}, 32'h1);
        rd(`CEC_MISC0_OFF, 32'h8000_ff00, "misc0 repeat wrap");
        chk("irq masked", {31'h0, irq}, 32'h0);
        rd(`CEC_IRQ_STAT_OFF, 32'h0000_0005, "irq status repeat");
        apb(1'b1, `CEC_IRQ_MASK_OFF, 32'h0000_0001, 4'hf);
        chk("irq unmasked", {31'h0, irq}, 32'h1);
        err(32'h0000_4000, 8'h11, 8'h22, 16'h0033);
        chk("ce no second wrap", {31'h0, ce}, 32'h0);
        rd(`CEC_MISC0_OFF, 32'h8000_ff01, "misc0 after wrap");
        err(32'h0000_5000, 8'h11, 8'h22, 16'h0033);
        chk("ce other wrap", {31'h0, ce}, 32'h1);
        rd(`CEC_MISC0_OFF, 32'hc000_0001, "misc0 both flags");
        rd(`CEC_IRQ_STAT_OFF, 32'h0000_0007, "irq status both");
        apb(1'b1, `CEC_MISC0_OFF, 32'hc000_0000, 4'h8);
        rd(`CEC_MISC0_OFF, 32'h0000_0001, "misc0 flags cleared");
        apb(1'b1, `CEC_IRQ_STAT_OFF, 32'h0000_0007, 4'hf);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        rd(`CEC_IRQ_STAT_OFF, 32'h0000_0000, "irq status cleared");
        rd(12'h018, 32'h0000_0000, "unmapped data");
        chk("unmapped error", {31'h0, rerr}, 32'h1);
    endtask

    // Watchdog against a hung handshake
    initial begin
        repeat (5000) @(posedge pclk);
        failures++;
        stop_test();
    end

    // Reset, then the scenarios in order
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
        err_valid = 1'b0;
        err_addr = 32'h0000_0000;
        err_impl_code = 8'h00;
        err_arch_code = 8'h00;
        err_misc_loc = 16'h0000;
        failures = 0;
        comparisons = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_capture();
        t_same_other();
        t_valid_bits();
        t_overflow();
        stop_test();
    end
endmodule
`default_nettype wire
